/* File: core/caw_map.vh */
// Word offsets, bit positions, reset values and codes of the auxiliary status words
`ifndef CAW_MAP_VH
`define CAW_MAP_VH

// ----------------------------------------------------------------------------
// Word offsets in the auxiliary word area
// ----------------------------------------------------------------------------
`define CAW_OFS_HOUR_DATE      8'h13
`define CAW_OFS_MONTH_YEAR     8'h14
`define CAW_OFS_WDAY_CTRL      8'h15
`define CAW_OFS_IO_COUNTS      8'h16
`define CAW_OFS_PWR_DOWN       8'h17
`define CAW_OFS_STATUS         8'h18

// ----------------------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------------------
`define CAW_BIT_ADJUST         13
`define CAW_BIT_HALT           14
`define CAW_BIT_LOAD           15
`define CAW_BIT_ERR_POWERUP    0
`define CAW_BIT_ERR_STARTUP    1
`define CAW_BIT_ERR_RUN        2
`define CAW_BIT_PORT_PERIPH    3
`define CAW_BIT_PORT_SERIAL    4
`define CAW_BIT_LONG_CYCLE     5

// ----------------------------------------------------------------------------
// Calendar limits and reset values (BCD)
// ----------------------------------------------------------------------------
`define CAW_BCD_ZERO           8'h00
`define CAW_BCD_ONE            8'h01
`define CAW_SEC_MAX            8'h59
`define CAW_SEC_HALF           8'h30
`define CAW_MIN_MAX            8'h59
`define CAW_HOUR_MAX           8'h23
`define CAW_MONTH_MAX          8'h12
`define CAW_YEAR_MAX           8'h99
`define CAW_WDAY_MAX           8'h06
`define CAW_DAYS_31            8'h31
`define CAW_DAYS_30            8'h30
`define CAW_DAYS_29            8'h29
`define CAW_DAYS_28            8'h28
`define CAW_MONTH_FEB          8'h02
`define CAW_WORD_ZERO          16'h0000

// ----------------------------------------------------------------------------
// Bus error codes
// ----------------------------------------------------------------------------
`define CAW_ERR_KIND_INPUT     3'h0
`define CAW_ERR_KIND_OUTPUT    3'h1
`define CAW_ERR_KIND_SLOT1     3'h2
`define CAW_ERR_KIND_SLOT2     3'h3
`define CAW_ERR_KIND_ENDCOVER  3'h4
`define CAW_CODE_OUT_TENS_LO   4'h8
`define CAW_CODE_OUT_TENS_HI   4'h9
`define CAW_CODE_SLOT1         8'hF0
`define CAW_CODE_SLOT2         8'hF1
`define CAW_CODE_ENDCOVER      8'hFF
`define CAW_CODE_NONE          8'h00

`endif

/* File: core/caw_bcd_step.v */
// Two-digit BCD incrementer with wrap between a low and a high bound
`timescale 1ns/1ns

module caw_bcd_step
(
  // Current value and bounds
  input  wire [7:0] value_in,
  input  wire [7:0] low_in,
  input  wire [7:0] high_in,
  input  wire       en_in,
  // Result
  output reg  [7:0] next_out,
  output reg        carry_out
);

  always @*
  begin
    next_out  = value_in;
    carry_out = 1'b0;
    if (en_in)
    begin
      if (value_in >= high_in)
      begin
        // Out-of-range values written by software also wrap here
        next_out  = low_in;
        carry_out = 1'b1;
      end
      else if (value_in[3:0] == 4'h9)
        next_out = {value_in[7:4] + 4'h1, 4'h0};
      else
        next_out = {value_in[7:4], value_in[3:0] + 4'h1};
    end
  end

endmodule // caw_bcd_step

/* File: core/caw_aux_words.v */
// Auxiliary status and control words: calendar, I/O counts, power-down count, error flags
`timescale 1ns/1ns
`include "caw_map.vh"

module caw_aux_words
(
  // Clock and reset
  input  wire        ref_clk_in,
  input  wire        rst_in,
  // Word access port
  input  wire [7:0]  addr_in,
  input  wire        rd_en_in,
  input  wire        wr_en_in,
  input  wire [15:0] wr_data_in,
  output reg  [15:0] rd_data_out,
  // Clock module
  input  wire        clk_module_present_in,
  input  wire        sec_tick_in,
  output reg         clock_running_out,
  // Power supply
  input  wire        power_down_in,
  // I/O allocation
  input  wire        io_alloc_valid_in,
  input  wire        io_overflow_in,
  input  wire [7:0]  in_words_in,
  input  wire [7:0]  out_words_in,
  // Setup block checks
  input  wire        setup_powerup_chk_in,
  input  wire        setup_powerup_err_in,
  input  wire        setup_startup_chk_in,
  input  wire        setup_startup_err_in,
  input  wire        setup_run_chk_in,
  input  wire        setup_run_err_in,
  // Port settings and cycle monitor
  input  wire        periph_port_changing_in,
  input  wire        serial_port_changing_in,
  input  wire        cycle_done_in,
  input  wire [15:0] cycle_time_in,
  input  wire [15:0] cycle_limit_in,
  // I/O bus error report
  input  wire        bus_err_valid_in,
  input  wire [2:0]  bus_err_kind_in,
  input  wire [3:0]  bus_err_word_in
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [7:0]  sec;
  reg  [7:0]  minute;
  reg  [7:0]  hour;
  reg  [7:0]  date;
  reg  [7:0]  month;
  reg  [7:0]  year;
  reg  [7:0]  wday;
  reg         halt;
  reg         load;
  reg         adjust;
  reg  [7:0]  in_count;
  reg  [7:0]  out_count;
  reg  [15:0] pwr_count;
  reg         err_powerup;
  reg         err_startup;
  reg         err_run;
  reg         port_periph;
  reg         port_serial;
  reg         long_cycle;
  reg  [7:0]  bus_err_code;

  wire        wr_hd   = wr_en_in && (addr_in == `CAW_OFS_HOUR_DATE);
  wire        wr_my   = wr_en_in && (addr_in == `CAW_OFS_MONTH_YEAR);
  wire        wr_ctrl = wr_en_in && (addr_in == `CAW_OFS_WDAY_CTRL);
  wire        wr_pwr  = wr_en_in && (addr_in == `CAW_OFS_PWR_DOWN);

  // --------------------------------------------------------------------------
  // Calendar carry chain
  // --------------------------------------------------------------------------
  // Clock only moves with the module fitted and not halted
  wire        running  = clk_module_present_in && !halt && !load;
  // Adjust takes the cycle over; a tick landing on it is dropped
  wire        do_adjust = running && adjust;
  wire        do_tick   = running && !adjust && sec_tick_in;
  wire        round_up  = (sec >= `CAW_SEC_HALF);

  wire [7:0]  next_sec;
  wire [7:0]  next_min;
  wire [7:0]  next_hour;
  wire [7:0]  next_date;
  wire [7:0]  next_month;
  wire [7:0]  next_year;
  wire [7:0]  next_wday;
  wire        sec_carry;
  wire        min_carry;
  wire        hour_carry;
  wire        date_carry;
  wire        month_carry;
  wire        min_en   = (do_tick && sec_carry) || (do_adjust && round_up);
  wire        hour_en  = min_en && min_carry;
  wire        date_en  = hour_en && hour_carry;
  wire        month_en = date_en && date_carry;
  wire        year_en  = month_en && month_carry;
  reg  [7:0]  date_max;
  wire        leap_year;

  // BCD year divisible by four: even tens with 0/4/8, odd tens with 2/6
  assign leap_year = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                             : (year[3:0] == 4'h0 || year[3:0] == 4'h4 ||
                                year[3:0] == 4'h8);

  always @*
  begin
    date_max = `CAW_DAYS_31;
    case (month)
      8'h04, 8'h06, 8'h09, 8'h11: date_max = `CAW_DAYS_30;
      `CAW_MONTH_FEB:             date_max = leap_year ? `CAW_DAYS_29 : `CAW_DAYS_28;
      default:                    date_max = `CAW_DAYS_31;
    endcase
  end

  caw_bcd_step u_sec
  (
    .value_in  (sec),
    .low_in    (`CAW_BCD_ZERO),
    .high_in   (`CAW_SEC_MAX),
    .en_in     (do_tick),
    .next_out  (next_sec),
    .carry_out (sec_carry)
  );

  caw_bcd_step u_min
  (
    .value_in  (minute),
    .low_in    (`CAW_BCD_ZERO),
    .high_in   (`CAW_MIN_MAX),
    .en_in     (min_en),
    .next_out  (next_min),
    .carry_out (min_carry)
  );

  caw_bcd_step u_hour
  (
    .value_in  (hour),
    .low_in    (`CAW_BCD_ZERO),
    .high_in   (`CAW_HOUR_MAX),
    .en_in     (hour_en),
    .next_out  (next_hour),
    .carry_out (hour_carry)
  );

  caw_bcd_step u_date
  (
    .value_in  (date),
    .low_in    (`CAW_BCD_ONE),
    .high_in   (date_max),
    .en_in     (date_en),
    .next_out  (next_date),
    .carry_out (date_carry)
  );

  caw_bcd_step u_month
  (
    .value_in  (month),
    .low_in    (`CAW_BCD_ONE),
    .high_in   (`CAW_MONTH_MAX),
    .en_in     (month_en),
    .next_out  (next_month),
    .carry_out (month_carry)
  );

  caw_bcd_step u_year
  (
    .value_in  (year),
    .low_in    (`CAW_BCD_ZERO),
    .high_in   (`CAW_YEAR_MAX),
    .en_in     (year_en),
    .next_out  (next_year),
    .carry_out ()
  );

  caw_bcd_step u_wday
  (
    .value_in  (wday),
    .low_in    (`CAW_BCD_ZERO),
    .high_in   (`CAW_WDAY_MAX),
    .en_in     (date_en),
    .next_out  (next_wday),
    .carry_out ()
  );

  // --------------------------------------------------------------------------
  // Calendar registers and clock controls
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sec    <= `CAW_BCD_ZERO;
      minute <= `CAW_BCD_ZERO;
      hour   <= `CAW_BCD_ZERO;
      date   <= `CAW_BCD_ONE;
      month  <= `CAW_BCD_ONE;
      year   <= `CAW_BCD_ZERO;
      wday   <= `CAW_BCD_ZERO;
      halt   <= 1'b0;
      load   <= 1'b0;
      adjust <= 1'b0;
    end
    else
    begin
      sec    <= do_adjust ? `CAW_BCD_ZERO : next_sec;
      minute <= next_min;
      wday   <= next_wday;
      if (halt && wr_hd)
      begin
        hour <= wr_data_in[7:0];
        date <= wr_data_in[15:8];
      end
      else
      begin
        hour <= next_hour;
        date <= next_date;
      end
      if (halt && wr_my)
      begin
        month <= wr_data_in[7:0];
        year  <= wr_data_in[15:8];
      end
      else
      begin
        month <= next_month;
        year  <= next_year;
      end
      if (halt && wr_ctrl)
        wday <= wr_data_in[7:0];
      // A fresh software write wins over the self-clear in the same cycle
      if (wr_ctrl)
      begin
        halt   <= wr_data_in[`CAW_BIT_HALT];
        load   <= wr_data_in[`CAW_BIT_LOAD];
        adjust <= wr_data_in[`CAW_BIT_ADJUST];
      end
      else
      begin
        if (load)
        begin
          halt <= 1'b0;
          load <= 1'b0;
        end
        if (do_adjust)
          adjust <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Power-down counter
  // --------------------------------------------------------------------------
  wire [7:0]  next_pwr_lo;
  wire [7:0]  next_pwr_hi;
  wire        pwr_lo_carry;
  // Only a zero write clears; a clear meeting an event leaves a count of one
  wire [15:0] pwr_base = (wr_pwr && wr_data_in == `CAW_WORD_ZERO) ?
                         `CAW_WORD_ZERO : pwr_count;

  caw_bcd_step u_pwr_lo
  (
    .value_in  (pwr_base[7:0]),
    .low_in    (`CAW_BCD_ZERO),
    .high_in   (`CAW_YEAR_MAX),
    .en_in     (power_down_in),
    .next_out  (next_pwr_lo),
    .carry_out (pwr_lo_carry)
  );

  caw_bcd_step u_pwr_hi
  (
    .value_in  (pwr_base[15:8]),
    .low_in    (`CAW_BCD_ZERO),
    .high_in   (`CAW_YEAR_MAX),
    .en_in     (power_down_in && pwr_lo_carry),
    .next_out  (next_pwr_hi),
    .carry_out ()
  );

  // --------------------------------------------------------------------------
  // Status capture
  // --------------------------------------------------------------------------
  reg  [7:0]  next_code;
  wire [3:0]  word_low = (bus_err_word_in >= 4'hA) ? bus_err_word_in - 4'hA : bus_err_word_in;
  wire        word_ten = (bus_err_word_in >= 4'hA);

  always @*
  begin
    next_code = bus_err_code;
    case (bus_err_kind_in)
      `CAW_ERR_KIND_INPUT:    next_code = {3'h0, word_ten, word_low};
      `CAW_ERR_KIND_OUTPUT:   next_code = {word_ten ? `CAW_CODE_OUT_TENS_HI
                                                    : `CAW_CODE_OUT_TENS_LO, word_low};
      `CAW_ERR_KIND_SLOT1:    next_code = `CAW_CODE_SLOT1;
      `CAW_ERR_KIND_SLOT2:    next_code = `CAW_CODE_SLOT2;
      `CAW_ERR_KIND_ENDCOVER: next_code = `CAW_CODE_ENDCOVER;
      default:                next_code = bus_err_code;
    endcase
  end

  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pwr_count    <= `CAW_WORD_ZERO;
      in_count     <= `CAW_BCD_ZERO;
      out_count    <= `CAW_BCD_ZERO;
      err_powerup  <= 1'b0;
      err_startup  <= 1'b0;
      err_run      <= 1'b0;
      port_periph  <= 1'b0;
      port_serial  <= 1'b0;
      long_cycle   <= 1'b0;
      bus_err_code <= `CAW_CODE_NONE;
    end
    else
    begin
      pwr_count   <= {next_pwr_hi, next_pwr_lo};
      port_periph <= periph_port_changing_in;
      port_serial <= serial_port_changing_in;
      if (io_alloc_valid_in)
      begin
        in_count  <= io_overflow_in ? `CAW_BCD_ZERO : in_words_in;
        out_count <= io_overflow_in ? `CAW_BCD_ZERO : out_words_in;
      end
      // Each setup error flag is re-evaluated only by its own check and holds between checks
      if (setup_powerup_chk_in)
        err_powerup <= setup_powerup_err_in;
      if (setup_startup_chk_in)
        err_startup <= setup_startup_err_in;
      if (setup_run_chk_in)
        err_run <= setup_run_err_in;
      // BCD words order like binary, so a plain compare is exact
      if (cycle_done_in)
        long_cycle <= (cycle_time_in > cycle_limit_in);
      if (bus_err_valid_in)
        bus_err_code <= next_code;
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  reg  [15:0] next_rd;

  always @*
  begin
    next_rd = `CAW_WORD_ZERO;
    case (addr_in)
      `CAW_OFS_HOUR_DATE:  next_rd = {date, hour};
      `CAW_OFS_MONTH_YEAR: next_rd = {year, month};
      `CAW_OFS_WDAY_CTRL:  next_rd = {load, halt, adjust, 5'h00, wday};
      `CAW_OFS_IO_COUNTS:  next_rd = {out_count, in_count};
      `CAW_OFS_PWR_DOWN:   next_rd = pwr_count;
      `CAW_OFS_STATUS:     next_rd = {bus_err_code, 2'h0, long_cycle, port_serial,
                                      port_periph, err_run, err_startup, err_powerup};
      default:             next_rd = `CAW_WORD_ZERO;
    endcase
  end

  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_data_out       <= `CAW_WORD_ZERO;
      clock_running_out <= 1'b0;
    end
    else
    begin
      if (rd_en_in)
        rd_data_out <= next_rd;
      clock_running_out <= running;
    end
  end

endmodule // caw_aux_words

/* File: bench/caw_aux_words_chk.sv */
// Checker of the auxiliary status words, watching the top module ports
`timescale 1ns/1ns
module caw_aux_words_chk
(
  // Clock and reset
  input wire        ref_clk_in,
  input wire        rst_in,
  // Word access port
  input wire [7:0]  addr_in,
  input wire        rd_en_in,
  input wire        wr_en_in,
  input wire [15:0] wr_data_in,
  input wire [15:0] rd_data_out,
  // Clock module
  input wire        clk_module_present_in,
  input wire        clock_running_out,
  // Allocation and status sources
  input wire        power_down_in,
  input wire        io_alloc_valid_in,
  input wire        io_overflow_in,
  input wire [7:0]  in_words_in,
  input wire [7:0]  out_words_in,
  input wire        setup_powerup_chk_in,
  input wire        setup_powerup_err_in,
  input wire        periph_port_changing_in,
  input wire        serial_port_changing_in,
  input wire        cycle_done_in,
  input wire [15:0] cycle_time_in,
  input wire [15:0] cycle_limit_in,
  input wire        bus_err_valid_in,
  input wire [2:0]  bus_err_kind_in,
  input wire [3:0]  bus_err_word_in
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire wr15 = wr_en_in && addr_in == 8'h15;
  wire rd18 = rd_en_in && addr_in == 8'h18;

  function automatic [7:0] bus_code(input [2:0] k, input [3:0] w);
    reg [7:0] b;
    begin
      b = (w > 4'h9) ? {4'h1, w - 4'hA} : {4'h0, w};
      bus_code = (k == 3'h0) ? b : (k == 3'h1) ? b + 8'h80 :
                 (k == 3'h2) ? 8'hF0 : (k == 3'h3) ? 8'hF1 : 8'hFF;
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  property p_io_counts;
    io_alloc_valid_in ##1 (rd_en_in && addr_in == 8'h16 && !io_alloc_valid_in) |=>
      rd_data_out == ($past(io_overflow_in, 2) ? 16'h0000 :
                      {$past(out_words_in, 2), $past(in_words_in, 2)});
  endproperty
  a_io_counts: assert property (p_io_counts) else $error("io counts wrong");
  property p_pwrup_flag;
    setup_powerup_chk_in ##1 (rd18 && !setup_powerup_chk_in) |=>
      rd_data_out[0] == $past(setup_powerup_err_in, 2);
  endproperty
  a_pwrup_flag: assert property (p_pwrup_flag) else $error("setup flag wrong");
  property p_long_cycle;
    cycle_done_in ##1 (rd18 && !cycle_done_in) |=>
      rd_data_out[5] == ($past(cycle_time_in, 2) > $past(cycle_limit_in, 2));
  endproperty
  a_long_cycle: assert property (p_long_cycle) else $error("long cycle flag wrong");
  property p_port_flags;
    rd18 && !$past(rst_in) && $stable(periph_port_changing_in) &&
      $stable(serial_port_changing_in) |=>
      rd_data_out[4:3] == {$past(serial_port_changing_in), $past(periph_port_changing_in)};
  endproperty
  a_port_flags: assert property (p_port_flags) else $error("port flags wrong");
  property p_power_clear;
    wr_en_in && addr_in == 8'h17 && wr_data_in == 16'h0000 && !power_down_in ##1
      (rd_en_in && addr_in == 8'h17) |=> rd_data_out == 16'h0000;
  endproperty
  a_power_clear: assert property (p_power_clear) else $error("count not cleared");
  property p_halt_freeze;
    wr15 && wr_data_in[14] && !wr_data_in[15] ##1 !wr15 |=> !clock_running_out;
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("clock runs in halt");
  property p_load_resume;
    wr15 && wr_data_in[15:13] == 3'b110 && clk_module_present_in ##1 !wr15 ##1
      (!wr15 && clk_module_present_in) |=> clock_running_out;
  endproperty
  a_load_resume: assert property (p_load_resume) else $error("clock not resumed");
  property p_absent;
    !clk_module_present_in |=> !clock_running_out;
  endproperty
  a_absent: assert property (p_absent) else $error("clock runs without module");
  property p_bus_code;
    bus_err_valid_in && bus_err_kind_in < 3'h5 ##1 (rd18 && !bus_err_valid_in) |=>
      rd_data_out[15:8] == bus_code($past(bus_err_kind_in, 2), $past(bus_err_word_in, 2));
  endproperty
  a_bus_code: assert property (p_bus_code) else $error("bad bus code");
endmodule // caw_aux_words_chk

/* File: bench/caw_aux_words_test.sv */
// Self-checking testbench of the auxiliary status words
`timescale 1ns/1ns
module caw_aux_words_test;
  logic        ref_clk_in, rst_in, rd_en_in, wr_en_in, clk_module_present_in, sec_tick_in;
  logic        power_down_in, io_alloc_valid_in, io_overflow_in, bus_err_valid_in;
  logic        setup_powerup_chk_in, setup_powerup_err_in, setup_startup_chk_in;
  logic        setup_startup_err_in, setup_run_chk_in, setup_run_err_in;
  logic        periph_port_changing_in, serial_port_changing_in, cycle_done_in;
  logic [7:0]  addr_in, in_words_in, out_words_in, w, b;
  logic [15:0] wr_data_in, cycle_time_in, cycle_limit_in;
  logic [2:0]  bus_err_kind_in;
  logic [3:0]  bus_err_word_in;
  wire  [15:0] rd_data_out;
  wire         clock_running_out;
  integer      n_errors, num_checks, seed, i, k;

  caw_aux_words caw_aux_words_i
  (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .rd_en_in(rd_en_in),
    .wr_en_in(wr_en_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
    .clk_module_present_in(clk_module_present_in), .sec_tick_in(sec_tick_in),
    .clock_running_out(clock_running_out), .power_down_in(power_down_in),
    .io_alloc_valid_in(io_alloc_valid_in), .io_overflow_in(io_overflow_in),
    .in_words_in(in_words_in), .out_words_in(out_words_in),
    .setup_powerup_chk_in(setup_powerup_chk_in), .setup_powerup_err_in(setup_powerup_err_in),
    .setup_startup_chk_in(setup_startup_chk_in), .setup_startup_err_in(setup_startup_err_in),
    .setup_run_chk_in(setup_run_chk_in), .setup_run_err_in(setup_run_err_in),
    .periph_port_changing_in(periph_port_changing_in),
    .serial_port_changing_in(serial_port_changing_in), .cycle_done_in(cycle_done_in),
    .cycle_time_in(cycle_time_in), .cycle_limit_in(cycle_limit_in),
    .bus_err_valid_in(bus_err_valid_in), .bus_err_kind_in(bus_err_kind_in),
    .bus_err_word_in(bus_err_word_in)
  );

  initial
  begin
    ref_clk_in = 0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  // ---------------------------------------------------------------------------
  // Bus tasks; strobes stay up between accesses so back-to-back cycles occur
  // ---------------------------------------------------------------------------
  task step; @(posedge ref_clk_in); #1; endtask
  task acc(input logic we, re, input logic [7:0] ad, input logic [15:0] d);
    wr_en_in = we; rd_en_in = re; addr_in = ad; wr_data_in = d; step;
  endtask
  task idle; wr_en_in = 0; rd_en_in = 0; step; endtask
  task chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rdchk(input logic [7:0] ad, input logic [15:0] exp);
    acc(0, 1, ad, 16'h0000); chk(rd_data_out, exp);
  endtask
  function automatic logic [7:0] bcd(input integer v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction
  task ticks(input integer n);
    repeat (n) begin sec_tick_in = 1; step; sec_tick_in = 0; step; end
  endtask
  // Halt first: calendar writes are refused while the clock runs
  task set_time(input logic [7:0] h, d, m, yr, wd);
    acc(1, 0, 8'h15, 16'h4000); acc(1, 0, 8'h13, {d, h}); acc(1, 0, 8'h14, {yr, m});
    acc(1, 0, 8'h15, {8'hC0, wd}); idle; idle; idle;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge ref_clk_in);
    n_errors++;
    print_verdict;
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    seed = 32'h0580; n_errors = 0; num_checks = 0; rst_in = 1;
    {rd_en_in, wr_en_in, clk_module_present_in, sec_tick_in, power_down_in} = 0;
    {io_alloc_valid_in, io_overflow_in, bus_err_valid_in, cycle_done_in} = 0;
    {setup_powerup_chk_in, setup_powerup_err_in, setup_startup_chk_in} = 0;
    {setup_startup_err_in, setup_run_chk_in, setup_run_err_in} = 0;
    {periph_port_changing_in, serial_port_changing_in} = 0;
    {addr_in, in_words_in, out_words_in, bus_err_kind_in, bus_err_word_in} = 0;
    {wr_data_in, cycle_time_in, cycle_limit_in} = 0;
    repeat (16) step;
    rst_in = 0;
    rdchk(8'h13, 16'h0100);
    rdchk(8'h14, 16'h0001);
    rdchk(8'h15, 16'h0000);
    rdchk(8'h12, 16'h0000);
    acc(1, 0, 8'h13, 16'h1523); acc(1, 0, 8'h16, 16'h1234);
    acc(1, 0, 8'h18, 16'hFFFF); acc(1, 0, 8'h17, 16'h0005);
    rdchk(8'h13, 16'h0100);
    rdchk(8'h16, 16'h0000);
    rdchk(8'h17, 16'h0000);
    rdchk(8'h18, 16'h0000);
    $display("test reset and refused writes done");
    clk_module_present_in = 1;
    for (i = 0; i < 2; i++)
    begin
      k = (i == 0) ? 96 : $unsigned($random(seed)) % 100;
      w = $unsigned($random(seed)) % 7;
      set_time(8'h23, 8'h28, 8'h02, bcd(k), w);
      rdchk(8'h15, {8'h00, w});
      chk({15'h0, clock_running_out}, 16'h0001);
      ticks(3570);
      rdchk(8'h13, 16'h2823);
      acc(1, 0, 8'h15, 16'h2000); idle; idle; idle;
      rdchk(8'h15, {8'h00, (w == 8'h06) ? 8'h00 : w + 8'h01});
      rdchk(8'h13, {(k % 4 == 0) ? 8'h29 : 8'h01, 8'h00});
      rdchk(8'h14, {bcd(k), (k % 4 == 0) ? 8'h02 : 8'h03});
    end
    // Seconds below 30: adjust clears them and leaves the minute alone
    ticks(10); acc(1, 0, 8'h15, 16'h2000); idle; idle; ticks(3595);
    rdchk(8'h13, {(k % 4 == 0) ? 8'h29 : 8'h01, 8'h00});
    clk_module_present_in = 0;
    ticks(2);
    chk({15'h0, clock_running_out}, 16'h0000);
    clk_module_present_in = 1;
    $display("test calendar done");
    for (i = 0; i < 4; i++)
    begin
      in_words_in = bcd($unsigned($random(seed)) % 100);
      out_words_in = (i == 2) ? 8'h99 : bcd($unsigned($random(seed)) % 100);
      io_overflow_in = i[0];
      io_alloc_valid_in = 1; step; io_alloc_valid_in = 0;
      rdchk(8'h16, io_overflow_in ? 16'h0000 : {out_words_in, in_words_in});
    end
    k = 1 + $unsigned($random(seed)) % 30;
    repeat (k) begin power_down_in = 1; step; power_down_in = 0; step; end
    rdchk(8'h17, {8'h00, bcd(k)});
    acc(1, 0, 8'h17, 16'h0000); rdchk(8'h17, 16'h0000);
    $display("test counts done");
    cycle_limit_in = 16'h0102;
    for (i = 0; i < 8; i++)
    begin
      {setup_powerup_err_in, setup_startup_err_in, setup_run_err_in} = i[2:0];
      {serial_port_changing_in, periph_port_changing_in} = {i[1], i[0]};
      cycle_time_in = 16'h0100 + 16'(i);
      {setup_powerup_chk_in, setup_startup_chk_in, setup_run_chk_in, cycle_done_in} = 4'hF;
      step;
      {setup_powerup_chk_in, setup_startup_chk_in, setup_run_chk_in, cycle_done_in} = 4'h0;
      w = {2'h0, i > 2, i[1], i[0], i[0], i[1], i[2]};
      rdchk(8'h18, {8'h00, w});
    end
    for (i = 0; i < 6; i++)
    begin
      bus_err_kind_in = 3'(i);
      bus_err_word_in = (i == 1) ? 4'hF : 4'($random(seed));
      if (i < 5)
        b = (i == 0) ? bcd(bus_err_word_in) : (i == 1) ? bcd(bus_err_word_in) + 8'h80 :
            (i == 2) ? 8'hF0 : (i == 3) ? 8'hF1 : 8'hFF;
      bus_err_valid_in = 1; step; bus_err_valid_in = 0;
      rdchk(8'h18, {b, 8'h3F});
    end
    idle;
    $display("test status word done");
    print_verdict;
  end
endmodule // caw_aux_words_test

bind caw_aux_words caw_aux_words_chk caw_aux_words_chk_i
(
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .rd_en_in(rd_en_in),
  .wr_en_in(wr_en_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
  .clk_module_present_in(clk_module_present_in), .clock_running_out(clock_running_out),
  .power_down_in(power_down_in), .io_alloc_valid_in(io_alloc_valid_in),
  .io_overflow_in(io_overflow_in), .in_words_in(in_words_in), .out_words_in(out_words_in),
  .setup_powerup_chk_in(setup_powerup_chk_in), .setup_powerup_err_in(setup_powerup_err_in),
  .periph_port_changing_in(periph_port_changing_in),
  .serial_port_changing_in(serial_port_changing_in), .cycle_done_in(cycle_done_in),
  .cycle_time_in(cycle_time_in), .cycle_limit_in(cycle_limit_in),
  .bus_err_valid_in(bus_err_valid_in), .bus_err_kind_in(bus_err_kind_in),
  .bus_err_word_in(bus_err_word_in)
);
